// [hw/bst_tap.sv]
// boundary-scan test access port: controller, instruction and data registers
module bst_tap
   import bst_pkg::*;
#(
   parameter int              CELLS        = BST_BSR_CELLS,
   parameter logic [3:0]      ID_REVISION  = 4'h1,     // arbitrary value
   parameter logic [15:0]     ID_PART      = 16'h1234, // arbitrary value
   parameter logic [10:0]     ID_MAKER     = 11'h155   // arbitrary value
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   input  wire logic             i_tck,
   input  wire logic             i_tms,
   input  wire logic             i_tdi,
   input  wire logic             i_test_reset_n,
   output logic                  o_tdo,
   output logic                  o_tdo_oe,
   input  wire logic [CELLS-1:0] i_pin_side,
   input  wire logic [CELLS-1:0] i_core_side,
   output logic      [CELLS-1:0] o_lead,
   output logic                  o_extest
);
   if (CELLS < 2) begin : g_bad_cells
      $error("boundary chain too short");
   end

   // ------------------------------------------------------------
   // reset and pin synchronisation
   // ------------------------------------------------------------
   logic       rst_meta_q;
   logic       rst_q;
   logic [3:0] pin_sync;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;
   logic       tck_rise;
   logic       tck_fall;
   logic       tms_s;
   logic       tdi_s;
   logic       trst_s;
   logic [CELLS-1:0] pins_s;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_q <= 1'b0;
         rst_q      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_q      <= rst_meta_q;
      end
   end

   // test reset is asynchronous at the pin; it is also folded into the
   // tap reset so a short low pulse still clears the controller
   logic tap_rst_n;
   assign tap_rst_n = rst_q & i_test_reset_n;

   bst_sync #(
      .WIDTH (4)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst_n (rst_q),
      .i_async ({i_test_reset_n, i_tdi, i_tms, i_tck}),
      .o_sync  (pin_sync),
      .o_rise  (pin_rise),
      .o_fall  (pin_fall)
   );
   assign tck_rise = pin_rise[0] & trst_s;
   assign tck_fall = pin_fall[0];
   assign tms_s    = pin_sync[1];
   assign tdi_s    = pin_sync[2];
   assign trst_s   = pin_sync[3];
   bst_sync #(.WIDTH (CELLS)) u_pin_sync (.i_clk (i_clk), .i_rst_n (rst_q),
      .i_async (i_pin_side), .o_sync (pins_s), .o_rise (), .o_fall ());

   // ------------------------------------------------------------
   // controller
   // ------------------------------------------------------------
   bst_state_t st_q;
   bst_state_t st_d;

   always_comb begin
      st_d = st_q;
      if (tck_rise) begin
         case (st_q)
            BST_RESET:  st_d = tms_s ? BST_RESET  : BST_IDLE;
            BST_IDLE:   st_d = tms_s ? BST_SEL_DR : BST_IDLE;
            BST_SEL_DR: st_d = tms_s ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: st_d = tms_s ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR:  st_d = tms_s ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR: st_d = tms_s ? BST_UPD_DR : BST_PAU_DR;
            BST_PAU_DR: st_d = tms_s ? BST_EX2_DR : BST_PAU_DR;
            BST_EX2_DR: st_d = tms_s ? BST_UPD_DR : BST_SH_DR;
            BST_UPD_DR: st_d = tms_s ? BST_SEL_DR : BST_IDLE;
            BST_SEL_IR: st_d = tms_s ? BST_RESET  : BST_CAP_IR;
            BST_CAP_IR: st_d = tms_s ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR:  st_d = tms_s ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR: st_d = tms_s ? BST_UPD_IR : BST_PAU_IR;
            BST_PAU_IR: st_d = tms_s ? BST_EX2_IR : BST_PAU_IR;
            BST_EX2_IR: st_d = tms_s ? BST_UPD_IR : BST_SH_IR;
            BST_UPD_IR: st_d = tms_s ? BST_SEL_DR : BST_IDLE;
            default:    st_d = BST_RESET;
         endcase
      end
      if (!trst_s) begin
         st_d = BST_RESET;
      end
   end

   always_ff @(posedge i_clk or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         st_q <= BST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // instruction and data registers
   // ------------------------------------------------------------
   logic [1:0]       ir_sh_q, ir_sh_d;
   logic [1:0]       ir_q, ir_d;
   logic             byp_q, byp_d;
   logic [31:0]      id_q, id_d;
   logic [CELLS-1:0] bsr_q, bsr_d;
   logic [CELLS-1:0] upd_q, upd_d;
   logic [31:0]      id_word;

   assign id_word = {ID_REVISION, ID_PART, ID_MAKER, 1'b1};

   always_comb begin
      ir_sh_d = ir_sh_q;
      ir_d    = ir_q;
      byp_d   = byp_q;
      id_d    = id_q;
      bsr_d   = bsr_q;
      upd_d   = upd_q;
      if (tck_rise) begin
         case (st_q)
            BST_CAP_IR: begin
               ir_sh_d = BST_IR_CAPTURE;
            end
            BST_SH_IR: begin
               ir_sh_d = {tdi_s, ir_sh_q[1]};
            end
            BST_UPD_IR: begin
               ir_d = ir_sh_q;
            end
            BST_CAP_DR: begin
               byp_d = 1'b0;
               id_d  = id_word;
               if (ir_q == BST_IR_EXTEST || ir_q == BST_IR_SAMPLE) begin
                  bsr_d = pins_s;
               end
            end
            BST_SH_DR: begin
               byp_d = tdi_s;
               id_d  = {tdi_s, id_q[31:1]};
               bsr_d = {tdi_s, bsr_q[CELLS-1:1]};
            end
            BST_UPD_DR: begin
               if (ir_q == BST_IR_EXTEST || ir_q == BST_IR_SAMPLE) begin
                  upd_d = bsr_q;
               end
            end
            default: begin
            end
         endcase
      end
      if (!trst_s || st_q == BST_RESET) begin
         ir_d = BST_IR_RESET;
      end
   end

   always_ff @(posedge i_clk or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         ir_sh_q <= 2'h0;
         ir_q    <= BST_IR_RESET;
         byp_q   <= 1'b0;
         id_q    <= 32'h0;
         bsr_q   <= '0;
         upd_q   <= '0;
      end else begin
         ir_sh_q <= ir_sh_d;
         ir_q    <= ir_d;
         byp_q   <= byp_d;
         id_q    <= id_d;
         bsr_q   <= bsr_d;
         upd_q   <= upd_d;
      end
   end

   // ------------------------------------------------------------
   // serial output, falling test clock edge
   // ------------------------------------------------------------
   logic tdo_q, tdo_d;
   logic oe_q, oe_d;
   logic dr_bit;

   always_comb begin
      case (ir_q)
         BST_IR_EXTEST: dr_bit = bsr_q[0];
         BST_IR_SAMPLE: dr_bit = bsr_q[0];
         BST_IR_IDCODE: dr_bit = id_q[0];
         default:       dr_bit = byp_q;
      endcase
      tdo_d = tdo_q;
      oe_d  = oe_q;
      if (tck_fall) begin
         oe_d  = (st_q == BST_SH_IR) || (st_q == BST_SH_DR);
         tdo_d = (st_q == BST_SH_IR) ? ir_sh_q[0] : dr_bit;
      end
   end

   always_ff @(posedge i_clk or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tdo_q <= 1'b0;
         oe_q  <= 1'b0;
      end else begin
         tdo_q <= tdo_d;
         oe_q  <= oe_d;
      end
   end

   // ------------------------------------------------------------
   // lead multiplexing
   // ------------------------------------------------------------
   logic [CELLS-1:0] lead_q, lead_d;
   logic             ext_q, ext_d;

   always_comb begin
      ext_d  = (ir_q == BST_IR_EXTEST);
      lead_d = ext_d ? upd_q : i_core_side;
   end

   // registered for a clean output; costs one clock of latency in mission mode
   always_ff @(posedge i_clk or negedge rst_q) begin
      if (!rst_q) begin
         lead_q <= '0;
         ext_q  <= 1'b0;
      end else begin
         lead_q <= lead_d;
         ext_q  <= ext_d;
      end
   end

   assign o_tdo    = tdo_q;
   assign o_tdo_oe = oe_q;
   assign o_lead   = lead_q;
   assign o_extest = ext_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_OE_SHIFT_ONLY: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
      $rose(oe_q) |-> $past(st_q == BST_SH_IR || st_q == BST_SH_DR))
      else $error("output enabled outside shift state");
   AST_CAPIR_PATTERN: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
      (tck_rise && st_q == BST_CAP_IR && trst_s) |=> (ir_sh_q == 2'h1))
      else $error("capture-instruction pattern wrong");
   AST_RESET_IR: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
      (st_q == BST_RESET) |=> (ir_q == BST_IR_IDCODE))
      else $error("reset did not select identification");
   AST_TRST_STATE: assert property (@(posedge i_clk) disable iff (!rst_q)
      !trst_s |=> (st_q == BST_RESET))
      else $error("test reset ignored");
   AST_TRANSPARENT: assert property (@(posedge i_clk) disable iff (!rst_q)
      (ir_q != BST_IR_EXTEST) ##1 (ir_q != BST_IR_EXTEST) |-> (lead_q == $past(i_core_side)))
      else $error("leads altered outside extest");
   AST_BYPASS_DELAY: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
      (tck_rise && st_q == BST_SH_DR && trst_s) |=> (byp_q == $past(tdi_s)))
      else $error("bypass stage not loaded");
   AST_ID_LSB: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
      (tck_rise && st_q == BST_CAP_DR && trst_s) |=> (id_q[0] == 1'b1))
      else $error("identification bit zero not one");
   AST_TDO_IR: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
      (tck_fall && st_q == BST_SH_IR) |=> (tdo_q == $past(ir_sh_q[0]) && oe_q))
      else $error("instruction bit not on output");
endmodule

// [hw/bst_pkg.sv]
// package: constants and types of the boundary-scan test access port
package bst_pkg;

   // ------------------------------------------------------------
   // instruction codes
   // ------------------------------------------------------------
   localparam logic [1:0] BST_IR_EXTEST  = 2'h0;
   localparam logic [1:0] BST_IR_SAMPLE  = 2'h1;
   localparam logic [1:0] BST_IR_IDCODE  = 2'h2;
   localparam logic [1:0] BST_IR_BYPASS  = 2'h3;
   localparam logic [1:0] BST_IR_CAPTURE = 2'h1;
   localparam logic [1:0] BST_IR_RESET   = 2'h2;

   // ------------------------------------------------------------
   // identification register layout
   // ------------------------------------------------------------
   localparam int BST_ID_REV_LSB   = 28;
   localparam int BST_ID_PART_LSB  = 12;
   localparam int BST_ID_MAKER_LSB = 1;
   localparam int BST_ID_REV_W     = 4;
   localparam int BST_ID_PART_W    = 16;
   localparam int BST_ID_MAKER_W   = 11;

   // ------------------------------------------------------------
   // boundary chain and timing
   // ------------------------------------------------------------
   localparam int BST_BSR_CELLS    = 177;
   localparam int BST_CLK_HZ       = 25000000;
   localparam int BST_TCK_MAX_HZ   = 10000000;
   localparam int BST_TCK_MIN_CYC  = (BST_CLK_HZ + BST_TCK_MAX_HZ - 1) / BST_TCK_MAX_HZ;

   typedef enum logic [15:0] {
      BST_RESET   = 16'h0001,
      BST_IDLE    = 16'h0002,
      BST_SEL_DR  = 16'h0004,
      BST_CAP_DR  = 16'h0008,
      BST_SH_DR   = 16'h0010,
      BST_EX1_DR  = 16'h0020,
      BST_PAU_DR  = 16'h0040,
      BST_EX2_DR  = 16'h0080,
      BST_UPD_DR  = 16'h0100,
      BST_SEL_IR  = 16'h0200,
      BST_CAP_IR  = 16'h0400,
      BST_SH_IR   = 16'h0800,
      BST_EX1_IR  = 16'h1000,
      BST_PAU_IR  = 16'h2000,
      BST_EX2_IR  = 16'h4000,
      BST_UPD_IR  = 16'h8000
   } bst_state_t;

endpackage

// [hw/bst_sync.sv]
// two-flop synchroniser with edge pulses for the test pins
module bst_sync
   import bst_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync,
   output logic      [WIDTH-1:0] o_rise,
   output logic      [WIDTH-1:0] o_fall
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] last_q;

   if (WIDTH < 1) begin : g_bad_width
      $error("bst_sync width must be positive");
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
         last_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign o_sync = sync_q;
   assign o_rise = sync_q & ~last_q;
   assign o_fall = ~sync_q & last_q;
endmodule

// [verif/bst_tester.sv]
// external test controller model driving the test pins
module bst_tester
   import bst_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe,
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   output logic      o_test_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------
   initial begin
      o_tck          = 1'b0;
      o_tms          = 1'b1;
      o_tdi          = 1'b0;
      o_test_reset_n = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // 8 clk period, 3.125 MHz; tms and tdi move with the fall
   task automatic pulse(input logic tms, input logic tdi, output logic tdo);
      @(posedge i_clk);
      o_tck <= 1'b0;
      o_tms <= tms;
      o_tdi <= tdi;
      wait_clk(4);
      o_tck <= 1'b1;
      wait_clk(3);
      // a released line reads as the inverse, so a bit taken while not driven fails
      tdo = i_tdo_oe ? i_tdo : ~i_tdo;
   endtask

   // pulse low then release, leave the controller in idle
   task automatic reset_tap();
      logic t;
      @(posedge i_clk);
      o_test_reset_n <= 1'b0;
      wait_clk(4);
      o_test_reset_n <= 1'b1;
      wait_clk(6);
      pulse(1'b0, ~o_tdi, t);
   endtask

   // idle to shift, n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input logic [176:0] din, input int n,
                       output logic [176:0] dout);
      logic t;
      dout = '0;
      pulse(1'b1, ~o_tdi, t);
      if (ir) pulse(1'b1, ~o_tdi, t);
      pulse(1'b0, ~o_tdi, t);
      pulse(1'b0, ~o_tdi, t);
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, din[i], t);
         dout[i] = t;
      end
      pulse(1'b1, ~o_tdi, t);
      pulse(1'b0, ~o_tdi, t);
   endtask
endmodule

// [verif/boundary_scan_tap_test.sv]
// self-checking bench of the boundary-scan test access port
module boundary_scan_tap_test
   import bst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [3:0]  REV   = 4'hA;     // arbitrary value
   localparam logic [15:0] PART  = 16'h5A3C; // arbitrary value
   localparam logic [10:0] MAKER = 11'h2B7;  // arbitrary value
   localparam logic [31:0] ID    = {REV, PART, MAKER, 1'b1};

   logic         clk;
   logic         reset_n;
   logic         tck;
   logic         tms;
   logic         tdi;
   logic         trst_n;
   logic         tdo;
   logic         tdo_oe;
   logic         extest;
   logic [176:0] pin;
   logic [176:0] core;
   logic [176:0] lead;
   logic [31:0]  rng;
   int           errors;
   int           checks_done;

   // ----------------------------------------------------------
   // instances
   // ----------------------------------------------------------
   bst_tap #(.ID_REVISION(REV), .ID_PART(PART), .ID_MAKER(MAKER)) i_bst_tap (
      .i_clk(clk), .i_reset_n(reset_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .i_test_reset_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pin_side(pin),
      .i_core_side(core), .o_lead(lead), .o_extest(extest));

   bst_tester i_bst_tester (
      .i_clk(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms),
      .o_tdi(tdi), .o_test_reset_n(trst_n));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic rnd(output logic [176:0] v);
      v = '0;
      for (int k = 0; k < 6; k++) begin
         rng = xs(rng);
         v = {v[144:0], rng};
      end
   endtask

   // captured chain as it should leave the serial output
   function automatic logic [176:0] expect_dr(input logic [1:0] c, input logic [176:0] d);
      case (c)
         BST_IR_BYPASS: return {d[175:0], 1'b0};
         BST_IR_IDCODE: return {d[144:0], ID};
         default:       return pin;
      endcase
   endfunction

   task automatic check(input logic [176:0] seen, input logic [176:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------
   // clock, watchdog, sequence
   // ----------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      stop_test();
   end

   initial begin
      logic [176:0] din;
      logic [176:0] dout;
      logic [176:0] pat;
      logic [176:0] tmp;
      logic [1:0]   code;
      logic         t;
      errors = 0;
      checks_done = 0;
      rng = 32'h0001_3EEC;
      reset_n = 1'b0;
      pin = '0;
      core = '0;
      pat = '0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rnd(tmp);
      core <= tmp;
      i_bst_tester.reset_tap();
      check(tdo_oe, 1'b0);
      check(extest, 1'b0);
      check(lead, core);
      i_bst_tester.scan(1'b0, '0, 32, dout);
      check(dout[31:0], ID);
      $display("test idcode after reset done");
      for (int k = 0; k < 4; k++) begin
         code = (k == 0) ? BST_IR_SAMPLE : (k == 1) ? BST_IR_EXTEST :
                (k == 2) ? BST_IR_BYPASS : BST_IR_IDCODE;
         i_bst_tester.scan(1'b1, {175'h0, code}, 2, dout);
         // instruction lands on the last rise; extest flag and leads follow a clock later
         repeat (2) @(posedge clk);
         check(dout[1:0], 2'h1);
         check(extest, code == BST_IR_EXTEST);
         check(tdo_oe, 1'b0);
         if (code == BST_IR_EXTEST) check(lead, pat);
         rnd(din);
         rnd(tmp);
         pin <= tmp;
         rnd(tmp);
         core <= tmp;
         i_bst_tester.scan(1'b0, din, 177, dout);
         check(dout, expect_dr(code, din));
         repeat (2) @(posedge clk);
         check(lead, (code == BST_IR_EXTEST) ? din : core);
         if (code == BST_IR_SAMPLE) pat = din;
         $display("test instruction %0d done", code);
      end
      i_bst_tester.scan(1'b1, {175'h0, BST_IR_EXTEST}, 2, dout);
      i_bst_tester.pulse(1'b1, 1'b0, t);
      i_bst_tester.pulse(1'b0, 1'b0, t);
      i_bst_tester.pulse(1'b0, 1'b0, t);
      i_bst_tester.pulse(1'b0, 1'b1, t);
      check(tdo_oe, 1'b1);
      i_bst_tester.reset_tap();
      check(extest, 1'b0);
      check(tdo_oe, 1'b0);
      check(lead, core);
      i_bst_tester.scan(1'b0, '0, 32, dout);
      check(dout[31:0], ID);
      $display("test reset mid scan done");
      i_bst_tester.scan(1'b1, {175'h0, BST_IR_BYPASS}, 2, dout);
      for (int k = 0; k < 5; k++) i_bst_tester.pulse(1'b1, 1'b0, t);
      i_bst_tester.pulse(1'b0, 1'b0, t);
      i_bst_tester.scan(1'b0, '0, 32, dout);
      check(dout[31:0], ID);
      $display("test reset by mode select done");
      stop_test();
   end
endmodule
